// ### hw/tof_spi_response_readout.sv
// Serial command engine, response encoder, readout buffer and page registers
`timescale 1ns/1ps
`include "tof_cfg.svh"

module tof_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     in_valid,
	output logic                          in_ready,
	input  wire logic [WIDTH-1:0]         in_data,
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic [WIDTH-1:0]              out_data,
	output logic [$clog2(DEPTH+1)-1:0]    count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0]         mem_r [DEPTH];
	logic [AW-1:0]            wr_r;
	logic [AW-1:0]            rd_r;
	logic [$clog2(DEPTH+1)-1:0] cnt_r;
	logic                     push;
	logic                     pop;

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("FIFO depth must be a power of two, at least 2");
	end

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign in_ready  = cnt_r != DEPTH[$clog2(DEPTH+1)-1:0];
	assign out_valid = cnt_r != '0;
	assign out_data  = mem_r[rd_r];
	assign count     = cnt_r;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= rd_r + 1'b1;
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule // tof_byte_fifo

// Notes on behaviour
// - Idle NOP answers code 000, zeros
// - Read done answers 001, address, value
// - Write done answers 010, address, value
// - Read busy answers 011, fixed patterns
// - Page select answers 100 with pointer
// - Write busy answers 110, fixed patterns
// - Boot answers 111 with boot patterns
// - Abort idles, answers 111 abort patterns
// - Bad frame length answers 111 error
// - Not ready answers 111, all ones
// - Buffer holds one double-row, or pixel
// - Emptied double-row refills from next one
// - Data-available pin follows buffer occupancy
// - Status register gives ready, byte count
// - Shadow values apply at next exposure
// - Reserved untouched; reset restores defaults
// - Two 2-bit phase-step selectors per frame
// - Bit 4 emitter on, bit 5 off
// - Answer comes in the following frame
// - Commands during busy write are ignored
module tof_spi_response_readout #(
	parameter logic [7:0] CHIP_TYPE  = 8'h5a, // Arbitrary value
	parameter logic [7:0] CHIP_REV   = 8'h01, // Arbitrary value
	parameter int         ROW_BYTES  = 16,
	parameter int         FIFO_DEPTH = 16
) (
	input  wire logic       CLK,
	input  wire logic       RST_N,
	input  wire logic       SCLK,
	input  wire logic       NSS_N,
	input  wire logic       MOSI,
	output logic            MISO_O,
	output logic            MISO_OE,
	input  wire logic       PIX_VALID,
	input  wire logic [7:0] PIX_DATA,
	output logic            PIX_READY,
	input  wire logic [7:0] SAT_TOP,
	input  wire logic [7:0] SAT_BOT,
	input  wire logic       ONE_PIXEL,
	input  wire logic       EXPOSURE_START,
	output logic            DATA_RDY,
	output logic [3:0]      PHASE_F1,
	output logic [3:0]      PHASE_F2,
	output logic [1:0]      ILLUM_F1,
	output logic [1:0]      ILLUM_F2,
	output logic [1:0]      ILLUM_GRAY
);
	localparam int CW = $clog2(FIFO_DEPTH + 1);

	if (ROW_BYTES < 2 || ROW_BYTES > 63 || ROW_BYTES > FIFO_DEPTH) begin : g_chk
		$error("Double-row length must fit the FIFO and the 6-bit count");
	end

	logic [2:0]  sclk_s;
	logic [2:0]  nss_s;
	logic [1:0]  mosi_s;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        frame_start;
	logic        frame_end;
	logic [15:0] rx_r;
	logic [4:0]  bits_r;
	logic [15:0] tx_r;
	logic        miso_r;
	logic        miso_oe_r;
	logic [15:0] resp_r;
	logic        shown_r;
	logic [15:0] answer;
	tof_pkg::op_t op_r;
	logic [11:0] op_cnt_r;
	logic [7:0]  op_addr_r;
	logic [7:0]  op_data_r;
	logic [2:0]  page_r;
	logic [2:0]  cmd;
	logic [7:0]  abs_addr;
	logic        op_done;
	logic [7:0]  rd_value;
	logic        wr_en;
	logic        pop_pix;
	logic [7:0]  nvm_addr_r;
	logic [7:0]  nvm_data_r;
	logic [7:0]  phase_f1_r;
	logic [7:0]  phase_f2_r;
	logic [7:0]  illum_f1_r;
	logic [7:0]  illum_f2_r;
	logic [7:0]  illum_gray_r;
	logic [3:0]  phase_f1_out_r;
	logic [3:0]  phase_f2_out_r;
	logic [1:0]  illum_f1_out_r;
	logic [1:0]  illum_f2_out_r;
	logic [1:0]  illum_gray_out_r;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [7:0]  fifo_out_data;
	logic [CW-1:0] fifo_count;
	logic        pix_ready_r;
	logic [5:0]  avail_r;
	logic [5:0]  row_len;
	logic [7:0]  sat_top_r;
	logic [7:0]  sat_bot_r;
	logic        data_rdy_r;

	// Pin synchronisers; only the second and third stages are looked at
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sclk_s <= 3'h0;
			nss_s  <= 3'h7;
			mosi_s <= 2'h0;
		end else begin
			sclk_s <= {sclk_s[1:0], SCLK};
			nss_s  <= {nss_s[1:0], NSS_N};
			mosi_s <= {mosi_s[0], MOSI};
		end
	end

	assign sclk_rise   = sclk_s[1] && !sclk_s[2] && !nss_s[1];
	assign sclk_fall   = !sclk_s[1] && sclk_s[2] && !nss_s[1];
	assign frame_start = !nss_s[1] && nss_s[2];
	assign frame_end   = nss_s[1] && !nss_s[2];
	assign cmd         = rx_r[15:13];
	assign abs_addr    = {page_r, rx_r[12:8]};

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rx_r   <= 16'h0000;
			bits_r <= 5'h00;
		end else if (frame_start) begin
			bits_r <= 5'h00;
		end else if (sclk_rise) begin
			rx_r <= {rx_r[14:0], mosi_s[1]};
			if (bits_r != 5'h1f) begin
				bits_r <= bits_r + 5'h01;
			end
		end
	end

	// Answer shown in the coming frame
	always_comb begin
		case (op_r)
			tof_pkg::OP_BOOT:   answer = `RESP_BOOT;
			tof_pkg::OP_RELOAD: answer = `RESP_NOT_READY;
			tof_pkg::OP_READ:   answer = `RESP_RD_BUSY;
			tof_pkg::OP_WRITE:  answer = `RESP_WR_BUSY;
			default:            answer = resp_r;
		endcase
	end

	// Shifter loads at frame start, next bit leaves on each falling edge
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			tx_r      <= 16'h0000;
			miso_r    <= 1'b0;
			miso_oe_r <= 1'b0;
		end else if (frame_start) begin
			tx_r      <= answer;
			miso_r    <= answer[15];
			miso_oe_r <= 1'b1;
		end else if (frame_end) begin
			miso_oe_r <= 1'b0;
		end else if (sclk_fall) begin
			tx_r   <= {tx_r[14:0], 1'b0};
			miso_r <= tx_r[14];
		end
	end

	always_comb begin
		case (op_r)
			tof_pkg::OP_BOOT:   op_done = op_cnt_r == 12'(`BOOT_CYCLES - 1);
			tof_pkg::OP_READ:   op_done = op_cnt_r == 12'(`READ_CYCLES - 1);
			tof_pkg::OP_WRITE:  op_done = op_cnt_r == 12'(`WRITE_CYCLES - 1);
			tof_pkg::OP_RELOAD: op_done = op_cnt_r == 12'(`RELOAD_CYCLES - 1);
			default:            op_done = 1'b0;
		endcase
	end

	always_comb begin
		case (op_addr_r)
			`ADDR_CHIP_TYPE:  rd_value = CHIP_TYPE;
			`ADDR_CHIP_REV:   rd_value = CHIP_REV;
			`ADDR_NVM_ADDR:   rd_value = nvm_addr_r;
			`ADDR_NVM_DATA:   rd_value = nvm_data_r;
			`ADDR_PHASE_F1:   rd_value = phase_f1_r;
			`ADDR_ILLUM_F1:   rd_value = illum_f1_r;
			`ADDR_PHASE_F2:   rd_value = phase_f2_r;
			`ADDR_ILLUM_F2:   rd_value = illum_f2_r;
			`ADDR_ILLUM_GRAY: rd_value = illum_gray_r;
			`ADDR_PIX_DATA:   rd_value = avail_r != 6'h00 ? fifo_out_data : 8'h00;
			`ADDR_SUM_DATA:   rd_value = avail_r != 6'h00 ? fifo_out_data : 8'h00;
			`ADDR_SAT_TOP:    rd_value = sat_top_r;
			`ADDR_SAT_BOT:    rd_value = sat_bot_r;
			`ADDR_RD_STATUS:  rd_value = {data_rdy_r, 1'b0, avail_r};
			default:          rd_value = 8'h00;
		endcase
	end

	assign wr_en   = op_r == tof_pkg::OP_WRITE && op_done;
	assign pop_pix = op_r == tof_pkg::OP_READ && op_done && avail_r != 6'h00
		&& (op_addr_r == `ADDR_PIX_DATA || op_addr_r == `ADDR_SUM_DATA);

	// Command sequencer; a frame that ends while busy is dropped, except an abort during a read, which ends it
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			op_r      <= tof_pkg::OP_BOOT;
			op_cnt_r  <= 12'h000;
			op_addr_r <= 8'h00;
			op_data_r <= 8'h00;
			page_r    <= 3'h0;
			resp_r    <= `RESP_IDLE;
		end else if (op_r != tof_pkg::OP_IDLE) begin
			op_cnt_r <= op_cnt_r + 12'h001;
			if (op_done) begin
				op_r     <= tof_pkg::OP_IDLE;
				op_cnt_r <= 12'h000;
				case (op_r)
					tof_pkg::OP_READ:  resp_r <= {`RC_READ, op_addr_r[4:0], rd_value};
					tof_pkg::OP_WRITE: resp_r <= {`RC_WRITE, op_addr_r[4:0], op_data_r};
					default:           resp_r <= `RESP_IDLE;
				endcase
			end else if (frame_end && op_r == tof_pkg::OP_READ && bits_r == `FRAME_BITS
				&& cmd == `CMD_ABORT) begin
				op_r     <= tof_pkg::OP_IDLE;
				op_cnt_r <= 12'h000;
				resp_r   <= `RESP_ABORT;
			end
		end else if (frame_end) begin
			if (bits_r != `FRAME_BITS) begin
				resp_r <= `RESP_ERROR;
			end else begin
				case (cmd)
					`CMD_NOP: resp_r <= shown_r ? `RESP_IDLE : resp_r;
					`CMD_READ: begin
						op_r      <= tof_pkg::OP_READ;
						op_addr_r <= abs_addr;
					end
					`CMD_WRITE: begin
						op_r      <= tof_pkg::OP_WRITE;
						op_addr_r <= abs_addr;
						op_data_r <= rx_r[7:0];
					end
					`CMD_ABORT: resp_r <= `RESP_ABORT;
					`CMD_PAGE: begin
						page_r <= rx_r[10:8];
						resp_r <= {`RC_PAGE, 2'b00, rx_r[10:8], 8'h00};
					end
					`CMD_RESET: begin
						op_r   <= tof_pkg::OP_RELOAD;
						page_r <= 3'h0;
					end
					default: resp_r <= `RESP_ERROR;
				endcase
			end
		end
	end

	// Stored answer counts as delivered once an idle frame starts; a poll ending after that clears it
	always_ff @(posedge CLK) begin
		if (!RST_N || op_done) begin
			shown_r <= 1'b0;
		end else if (frame_start && op_r == tof_pkg::OP_IDLE) begin
			shown_r <= 1'b1;
		end
	end

	// Staged registers; a reload restores the factory values
	always_ff @(posedge CLK) begin
		if (!RST_N || (op_r == tof_pkg::OP_RELOAD && op_done)) begin
			nvm_addr_r   <= `RST_NVM;
			nvm_data_r   <= `RST_NVM;
			phase_f1_r   <= `RST_PHASE_F1;
			illum_f1_r   <= `RST_ILLUM_F1;
			phase_f2_r   <= `RST_PHASE_F2;
			illum_f2_r   <= `RST_ILLUM_F2;
			illum_gray_r <= `RST_ILLUM_GRAY;
		end else if (wr_en) begin
			case (op_addr_r)
				`ADDR_NVM_ADDR:   nvm_addr_r   <= op_data_r;
				`ADDR_NVM_DATA:   nvm_data_r   <= op_data_r;
				`ADDR_PHASE_F1:   phase_f1_r   <= op_data_r;
				`ADDR_ILLUM_F1:   illum_f1_r   <= op_data_r;
				`ADDR_PHASE_F2:   phase_f2_r   <= op_data_r;
				`ADDR_ILLUM_F2:   illum_f2_r   <= op_data_r;
				`ADDR_ILLUM_GRAY: illum_gray_r <= op_data_r;
				default:          nvm_addr_r   <= nvm_addr_r;
			endcase
		end
	end

	// Shadow copies reach the sequencer only at an exposure start
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			phase_f1_out_r   <= 4'(`RST_PHASE_F1);
			phase_f2_out_r   <= 4'(`RST_PHASE_F2);
			illum_f1_out_r   <= 2'(`RST_ILLUM_F1 >> `ILLUM_ON_BIT);
			illum_f2_out_r   <= 2'(`RST_ILLUM_F2 >> `ILLUM_ON_BIT);
			illum_gray_out_r <= 2'(`RST_ILLUM_GRAY >> `ILLUM_ON_BIT);
		end else if (EXPOSURE_START) begin
			phase_f1_out_r   <= {phase_f1_r[`PS_B_LSB +: 2], phase_f1_r[`PS_A_LSB +: 2]};
			phase_f2_out_r   <= {phase_f2_r[`PS_B_LSB +: 2], phase_f2_r[`PS_A_LSB +: 2]};
			illum_f1_out_r   <= {illum_f1_r[`ILLUM_OFF_BIT], illum_f1_r[`ILLUM_ON_BIT]};
			illum_f2_out_r   <= {illum_f2_r[`ILLUM_OFF_BIT], illum_f2_r[`ILLUM_ON_BIT]};
			illum_gray_out_r <= {illum_gray_r[`ILLUM_OFF_BIT], illum_gray_r[`ILLUM_ON_BIT]};
		end
	end

	tof_byte_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK),
		.rst_n     (RST_N),
		.in_valid  (PIX_VALID && pix_ready_r),
		.in_ready  (fifo_in_ready),
		.in_data   (PIX_DATA),
		.out_valid (fifo_out_valid),
		.out_ready (pop_pix),
		.out_data  (fifo_out_data),
		.count     (fifo_count)
	);

	assign row_len = ONE_PIXEL ? `PIX_ONE_BYTES : 6'(ROW_BYTES);

	// Ready is registered one word early so a push never meets a full FIFO
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			pix_ready_r <= 1'b0;
		end else begin
			pix_ready_r <= fifo_in_ready && fifo_count < CW'(FIFO_DEPTH - 1);
		end
	end

	// Double-row window over the FIFO, refilled once fully read
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			avail_r    <= 6'h00;
			sat_top_r  <= 8'h00;
			sat_bot_r  <= 8'h00;
			data_rdy_r <= 1'b0;
		end else begin
			if (avail_r == 6'h00 && fifo_count >= CW'(row_len) && fifo_out_valid) begin
				avail_r    <= row_len;
				sat_top_r  <= SAT_TOP;
				sat_bot_r  <= SAT_BOT;
				data_rdy_r <= 1'b1;
			end else if (pop_pix) begin
				avail_r    <= avail_r - 6'h01;
				data_rdy_r <= avail_r != 6'h01;
			end
		end
	end

	assign MISO_O     = miso_r;
	assign MISO_OE    = miso_oe_r;
	assign PIX_READY  = pix_ready_r;
	assign DATA_RDY   = data_rdy_r;
	assign PHASE_F1   = phase_f1_out_r;
	assign PHASE_F2   = phase_f2_out_r;
	assign ILLUM_F1   = illum_f1_out_r;
	assign ILLUM_F2   = illum_f2_out_r;
	assign ILLUM_GRAY = illum_gray_out_r;
endmodule // tof_spi_response_readout

// ### hw/tof_cfg.svh
// Constants of the time-of-flight serial command and readout block
`ifndef TOF_CFG_SVH
`define TOF_CFG_SVH

`define CLK_PERIOD_NS   10
`define BOOT_TIME_NS    10000
`define READ_TIME_NS    200
`define WRITE_TIME_NS   1000
`define RELOAD_TIME_NS  2000
`define BOOT_CYCLES     ((`BOOT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYCLES     ((`READ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_CYCLES    ((`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RELOAD_CYCLES   ((`RELOAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define FRAME_BITS      5'h10
`define CMD_NOP         3'h0
`define CMD_READ        3'h1
`define CMD_WRITE       3'h2
`define CMD_ABORT       3'h3
`define CMD_PAGE        3'h4
`define CMD_RESET       3'h6

`define RC_READ         3'h1
`define RC_WRITE        3'h2
`define RC_PAGE         3'h4
`define RESP_IDLE       16'h0000
`define RESP_RD_BUSY    16'h7333
`define RESP_WR_BUSY    16'hcccc
`define RESP_BOOT       16'hebff
`define RESP_ABORT      16'he38e
`define RESP_ERROR      16'hf5ff
`define RESP_NOT_READY  16'hffff

`define ADDR_CHIP_TYPE  8'h00
`define ADDR_CHIP_REV   8'h01
`define ADDR_NVM_ADDR   8'h11
`define ADDR_NVM_DATA   8'h12
`define ADDR_PHASE_F1   8'h22
`define ADDR_ILLUM_F1   8'h24
`define ADDR_PHASE_F2   8'h25
`define ADDR_ILLUM_F2   8'h27
`define ADDR_ILLUM_GRAY 8'h3c
`define ADDR_PIX_DATA   8'h4c
`define ADDR_SAT_TOP    8'h4d
`define ADDR_SAT_BOT    8'h4e
`define ADDR_SUM_DATA   8'h54
`define ADDR_RD_STATUS  8'h55

`define RST_PHASE_F1    8'h34
`define RST_ILLUM_F1    8'h00
`define RST_PHASE_F2    8'h3d
`define RST_ILLUM_F2    8'h00
`define RST_ILLUM_GRAY  8'h26
`define RST_NVM         8'h00

`define PS_A_LSB        0
`define PS_B_LSB        2
`define ILLUM_ON_BIT    4
`define ILLUM_OFF_BIT   5
`define STAT_RDY_BIT    7
`define PIX_ONE_BYTES   6'h02

`endif

// ### hw/tof_pkg.sv
// Types of the time-of-flight serial command and readout block
package tof_pkg;
	typedef enum logic [2:0] {
		OP_BOOT,
		OP_IDLE,
		OP_READ,
		OP_WRITE,
		OP_RELOAD
	} op_t;
endpackage

// ### verification/tof_readout_properties.sv
// Concurrent checks on the ports of the readout block
`timescale 1ns/1ps
module tof_readout_checker (
	input wire logic       CLK,
	input wire logic       RST_N,
	input wire logic       SCLK,
	input wire logic       NSS_N,
	input wire logic       MISO_O,
	input wire logic       MISO_OE,
	input wire logic       PIX_VALID,
	input wire logic       PIX_READY,
	input wire logic       EXPOSURE_START,
	input wire logic       DATA_RDY,
	input wire logic [3:0] PHASE_F1,
	input wire logic [3:0] PHASE_F2,
	input wire logic [1:0] ILLUM_F1,
	input wire logic [1:0] ILLUM_F2,
	input wire logic [1:0] ILLUM_GRAY
);
	logic [1:0]  fed_r;
	wire  [13:0] outs = {PHASE_F1, PHASE_F2, ILLUM_F1, ILLUM_F2, ILLUM_GRAY};
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// Saturating count of pixel bytes taken since reset
	always_ff @(posedge CLK) begin
		if (!RST_N)
			fed_r <= 2'h0;
		else if (PIX_VALID && PIX_READY && fed_r != 2'h3)
			fed_r <= fed_r + 2'h1;
	end
	sequence frame_open; !NSS_N [*6]; endsequence
	sequence frame_shut; NSS_N [*6]; endsequence
	a_reset_values: assert property (disable iff (1'b0) !RST_N |=>
		outs == {4'h4, 4'hd, 2'h0, 2'h0, 2'h2}) else $error("output defaults wrong in reset");
	a_reset_quiet: assert property (disable iff (1'b0) !RST_N |=>
		!MISO_OE && !MISO_O && !DATA_RDY && !PIX_READY) else $error("outputs active in reset");
	a_ready_after_rst: assert property ($rose(RST_N) |=> PIX_READY)
		else $error("pixel input not ready after reset");
	a_oe_frame_open: assert property (frame_open |=> MISO_OE)
		else $error("answer line not driven in frame");
	a_oe_frame_shut: assert property (frame_shut |=> !MISO_OE)
		else $error("answer line driven outside frame");
	a_miso_on_low: assert property (!$stable(MISO_O) |-> !SCLK)
		else $error("answer bit moved while serial clock high");
	a_shadow_hold: assert property (!$stable(outs) && $past(RST_N) |-> $past(EXPOSURE_START))
		else $error("staged output changed without exposure");
	a_rdy_needs_bytes: assert property ($rose(DATA_RDY) |-> fed_r >= 2'h2)
		else $error("data ready without buffered bytes");
endmodule // tof_readout_checker

bind tof_spi_response_readout tof_readout_checker chk_u (.CLK, .RST_N, .SCLK, .NSS_N, .MISO_O,
	.MISO_OE, .PIX_VALID, .PIX_READY, .EXPOSURE_START, .DATA_RDY, .PHASE_F1, .PHASE_F2,
	.ILLUM_F1, .ILLUM_F2, .ILLUM_GRAY);

// ### verification/spi_master_model.sv
// Behavioural serial master that frames commands and collects answers
`timescale 1ns/1ps
module spi_master_model (
	input  wire logic clk,
	output logic      sclk,
	output logic      nss_n,
	output logic      mosi,
	input  wire logic miso
);
	initial begin
		sclk = 1'b0;
		nss_n = 1'b1;
		mosi = 1'b0;
	end
	// Clock stands low between frames; data line shows the inverse of its last bit
	task automatic xfer(input logic [15:0] c, input int n, output logic [15:0] r);
		r = 16'h0000;
		// Start just after a rising edge so no link edge meets a sampling edge
		@(posedge clk);
		#1;
		nss_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			mosi = c[15-i];
			#62.5 sclk = 1'b1;
			r = {r[14:0], miso};
			#62.5 sclk = 1'b0;
		end
		mosi = ~mosi;
		nss_n = 1'b1;
		#100;
	endtask
endmodule // spi_master_model

// ### verification/tof_spi_response_readout_tb.sv
// Self-checking bench for the serial command and readout block
`timescale 1ns/1ps
module tof_spi_response_readout_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        sclk, nss_n, mosi, miso_o, miso_oe, pix_ready, data_rdy;
	logic        pix_valid = 1'b0;
	logic        one_pixel = 1'b0;
	logic        exp_start = 1'b0;
	logic [7:0]  pix_data = 8'h00;
	logic [7:0]  sat_top = 8'h00;
	logic [7:0]  sat_bot = 8'h00;
	logic [3:0]  ph1, ph2;
	logic [1:0]  il1, il2, ilg;
	logic [7:0]  feed_q[$], exp_q[$], regs_m[5], d;
	logic [7:0]  defs[5] = '{8'h34, 8'h00, 8'h3d, 8'h00, 8'h26};
	logic [4:0]  addr_m[5] = '{5'h02, 5'h04, 5'h05, 5'h07, 5'h1c};
	logic [15:0] r, exp_o;
	wire  [15:0] outs = {2'h0, ph1, ph2, il1, il2, ilg};
	int          mismatches = 0;
	int          checked = 0;
	int          k;
	always #5 clk = ~clk;
	tof_spi_response_readout dut_u (.CLK(clk), .RST_N(rst_n), .SCLK(sclk), .NSS_N(nss_n),
		.MOSI(mosi), .MISO_O(miso_o), .MISO_OE(miso_oe), .PIX_VALID(pix_valid),
		.PIX_DATA(pix_data), .PIX_READY(pix_ready), .SAT_TOP(sat_top), .SAT_BOT(sat_bot),
		.ONE_PIXEL(one_pixel), .EXPOSURE_START(exp_start), .DATA_RDY(data_rdy),
		.PHASE_F1(ph1), .PHASE_F2(ph2), .ILLUM_F1(il1), .ILLUM_F2(il2), .ILLUM_GRAY(ilg));
	spi_master_model mst_u (.clk(clk), .sclk(sclk), .nss_n(nss_n), .mosi(mosi),
		.miso(miso_oe ? miso_o : ~mosi));
	always @(posedge clk) begin
		if (pix_valid && pix_ready)
			void'(feed_q.pop_front());
		pix_valid <= feed_q.size() != 0;
		pix_data <= feed_q.size() != 0 ? feed_q[0] : 8'h00;
	end
	function automatic logic [15:0] resp(input logic [2:0] c, input logic [4:0] a,
		input logic [7:0] v);
		return {c, a, v};
	endfunction
	function automatic logic [15:0] outs_exp();
		return {2'h0, regs_m[0][3:0], regs_m[2][3:0], regs_m[1][5:4], regs_m[3][5:4],
			regs_m[4][5:4]};
	endfunction
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
		checked++;
		if (seen !== want) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic complete_run();
		if (mismatches == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Command frame, a wait long enough for any access, then a frame that fetches the answer
	task automatic op(input logic [15:0] c);
		mst_u.xfer(c, 16, r);
		repeat (120) @(posedge clk);
		mst_u.xfer(16'h0000, 16, r);
		@(posedge clk);
	endtask
	initial begin
		repeat (80000) @(posedge clk);
		mismatches++;
		complete_run();
	end
	initial begin
		void'($urandom(9126));
		regs_m = defs;
		exp_o = outs_exp();
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check("out_defaults", outs, exp_o);
		mst_u.xfer(16'h0000, 16, r);
		check("boot", r, 16'hebff);
		repeat (1000) @(posedge clk);
		mst_u.xfer(16'h0000, 16, r);
		check("idle", r, 16'h0000);
		op(resp(3'h1, 5'h00, 8'h00));
		check("chip_type", r, resp(3'h1, 5'h00, 8'h5a));
		op(resp(3'h1, 5'h05, 8'h00));
		check("unmapped", r, resp(3'h1, 5'h05, 8'h00));
		d = 8'($urandom);
		op(resp(3'h2, 5'h11, d));
		check("nvm_wr", r, resp(3'h2, 5'h11, d));
		op(resp(3'h1, 5'h11, 8'h00));
		check("nvm_rd", r, resp(3'h1, 5'h11, d));
		op(resp(3'h4, 5'h01, 8'h00));
		check("page", r, resp(3'h4, 5'h01, 8'h00));
		for (int i = 0; i < 5; i++) begin
			op(resp(3'h1, addr_m[i], 8'h00));
			check("reg_default", r, resp(3'h1, addr_m[i], defs[i]));
		end
		mst_u.xfer(resp(3'h1, 5'h02, 8'h00), 16, r);
		mst_u.xfer(16'h0000, 16, r);
		check("rd_busy", r, 16'h7333);
		mst_u.xfer(16'h0000, 16, r);
		check("rd_poll", r, resp(3'h1, 5'h02, regs_m[0]));
		d = 8'($urandom);
		mst_u.xfer(resp(3'h2, 5'h04, d), 16, r);
		mst_u.xfer(resp(3'h1, 5'h02, 8'h00), 4, r);
		check("wr_busy", r, 16'h000c);
		repeat (120) @(posedge clk);
		mst_u.xfer(16'h0000, 16, r);
		check("wr_drop", r, resp(3'h2, 5'h04, d));
		regs_m[1] = d;
		@(posedge clk);
		for (int i = 0; i < 8; i++) begin
			k = i < 4 ? 0 : $urandom_range(4);
			d = i < 4 ? {4'($urandom), 4'(i * 5)} : 8'($urandom);
			op(resp(3'h2, addr_m[k], d));
			check("shadow_wr", r, resp(3'h2, addr_m[k], d));
			check("shadow_hold", outs, exp_o);
			regs_m[k] = d;
			exp_start <= 1'b1;
			@(posedge clk);
			exp_start <= 1'b0;
			repeat (3) @(posedge clk);
			exp_o = outs_exp();
			check("shadow_apply", outs, exp_o);
		end
		mst_u.xfer(resp(3'h1, 5'h02, 8'h00), 12, r);
		mst_u.xfer(16'h0000, 16, r);
		check("bad_length", r, 16'hf5ff);
		op(resp(3'h1, 5'h02, 8'h00));
		check("resend", r, resp(3'h1, 5'h02, regs_m[0]));
		mst_u.xfer(16'ha000, 16, r);
		mst_u.xfer(16'h0000, 16, r);
		check("reserved", r, 16'hf5ff);
		mst_u.xfer(16'h6000, 16, r);
		mst_u.xfer(16'h0000, 16, r);
		check("abort", r, 16'he38e);
		mst_u.xfer(16'hc000, 16, r);
		mst_u.xfer(16'h0000, 8, r);
		check("not_ready", r, 16'h00ff);
		repeat (300) @(posedge clk);
		mst_u.xfer(16'h0000, 16, r);
		check("reload_idle", r, 16'h0000);
		op(resp(3'h4, 5'h01, 8'h00));
		op(resp(3'h1, 5'h02, 8'h00));
		check("reload_reg", r, resp(3'h1, 5'h02, 8'h34));
		sat_top <= 8'($urandom);
		sat_bot <= 8'($urandom);
		for (int i = 0; i < 40; i++) begin
			d = 8'($urandom);
			feed_q.push_back(d);
			exp_q.push_back(d);
		end
		repeat (300) @(posedge clk);
		check("fifo_full", 16'(pix_ready), 16'h0000);
		check("rdy_pin", 16'(data_rdy), 16'h0001);
		op(resp(3'h4, 5'h02, 8'h00));
		op(resp(3'h1, 5'h15, 8'h00));
		check("status", r, resp(3'h1, 5'h15, 8'h90));
		op(resp(3'h1, 5'h0d, 8'h00));
		check("sat_top", r, resp(3'h1, 5'h0d, sat_top));
		op(resp(3'h1, 5'h0e, 8'h00));
		check("sat_bot", r, resp(3'h1, 5'h0e, sat_bot));
		for (int i = 0; i < 32; i++) begin
			op(resp(3'h1, i[0] ? 5'h14 : 5'h0c, 8'h00));
			check("pixel", r, resp(3'h1, i[0] ? 5'h14 : 5'h0c, exp_q.pop_front()));
		end
		check("rdy_empty", 16'(data_rdy), 16'h0000);
		op(resp(3'h1, 5'h0c, 8'h00));
		check("empty_rd", r, resp(3'h1, 5'h0c, 8'h00));
		one_pixel <= 1'b1;
		repeat (20) @(posedge clk);
		op(resp(3'h1, 5'h15, 8'h00));
		check("one_pixel", r, resp(3'h1, 5'h15, 8'h82));
		complete_run();
	end
endmodule // tof_spi_response_readout_tb
